// ---- ccr_comparator_regs.sv ----
// Summary of operation
// - Control bit 4 enables comparator 1
// - Control bit 0 enables comparator 0, writable only while unlocked
// - Lock set makes control bits 2:0 read-only
// - Lock clear lets bits 2:0 take writes
// - Lock bit can be written only once
// - Strap high presets lock and comparator 0 enable
// - Sleep bit 1 keeps comparator 1 in deep sleep
// - Sleep bit 0 frozen like comparator 0 enable
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ccr_params.svh"

module ccr_comparator_regs
    import ccr_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    input  wire logic                   clock_enable,
    input  wire logic [`CCR_ADDR_W-1:0] address,
    input  wire logic [`CCR_DATA_W-1:0] write_data,
    input  wire logic                   write_strobe,
    input  wire logic                   read_strobe,
    output logic      [`CCR_DATA_W-1:0] read_data,
    input  wire logic                   comparator_boot_strap_pin,
    output logic                        comparator0_enable,
    output logic                        comparator1_enable,
    output logic                        comparator0_sleep_enable,
    output logic                        comparator1_sleep_enable
);

    // Packs the control fields into their register image
    function automatic logic [`CCR_DATA_W-1:0] compose_ctrl(
        input logic en1,
        input logic spare,
        input logic lock,
        input logic en0
    );
        logic [`CCR_DATA_W-1:0] img;
        img = `CCR_RST_DATA;
        img[`CCR_CTRL_EN1]   = en1;   // Reserved bits stay zero
        img[`CCR_CTRL_SPARE] = spare;
        img[`CCR_CTRL_LOCK]  = lock;
        img[`CCR_CTRL_EN0]   = en0;
        return img;
    endfunction

    // Packs the sleep fields into their register image
    function automatic logic [`CCR_DATA_W-1:0] compose_sleep(
        input logic en1,
        input logic en0
    );
        logic [`CCR_DATA_W-1:0] img;
        img = `CCR_RST_DATA;
        img[`CCR_SLP_EN1] = en1;      // Bits 7:2 read zero
        img[`CCR_SLP_EN0] = en0;
        return img;
    endfunction

    // Strap synchroniser and boot sequencing state
    logic      strap_meta;             // First stage, read only by strap_sync
    logic      strap_sync;             // Strap level safe to use
    ccr_boot_t boot_state;             // Boot sequence position
    ccr_boot_t next_boot_state;

    // Register fields
    logic      lock;                   // Comparator 0 configuration lock
    logic      lock_written;           // Lock field has taken its one write
    logic      spare;                  // Control bit 3, plain storage
    logic      next_lock;
    logic      next_lock_written;
    logic      next_spare;
    logic      next_en0;
    logic      next_en1;
    logic      next_slp0;
    logic      next_slp1;
    logic [`CCR_DATA_W-1:0] next_read_data;

    // Decoded accesses; writes are dropped while frozen or during boot, reads only while frozen
    logic      wr_ctrl;
    logic      wr_sleep;
    logic      rd_any;

    assign wr_ctrl  = clock_enable && write_strobe && (boot_state == ccr_boot_run) &&
                      (address == `CCR_OFF_CTRL);
    assign wr_sleep = clock_enable && write_strobe && (boot_state == ccr_boot_run) &&
                      (address == `CCR_OFF_SLEEP);
    assign rd_any   = clock_enable && read_strobe;

    // Two-stage strap synchroniser; the pin is asynchronous to clock
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            strap_meta <= `CCR_RST_BIT;
            strap_sync <= `CCR_RST_BIT;
        end else if (clock_enable) begin
            strap_meta <= comparator_boot_strap_pin;
            strap_sync <= strap_meta;
        end
    end

    // Boot sequence: two fill cycles, then one load of the strap defaults
    always_comb begin
        next_boot_state = boot_state;
        case (boot_state)
            ccr_boot_fill0: next_boot_state = ccr_boot_fill1;
            ccr_boot_fill1: next_boot_state = ccr_boot_load;
            ccr_boot_load:  next_boot_state = ccr_boot_run;
            ccr_boot_run:   next_boot_state = ccr_boot_run;
            default:        next_boot_state = ccr_boot_fill0;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            boot_state <= ccr_boot_fill0;
        end else if (clock_enable) begin
            boot_state <= next_boot_state;
        end
    end

    // Next register values
    always_comb begin
        next_lock         = lock;
        next_lock_written = lock_written;
        next_spare        = spare;
        next_en0          = comparator0_enable;
        next_en1          = comparator1_enable;
        next_slp0         = comparator0_sleep_enable;
        next_slp1         = comparator1_sleep_enable;
        // Strap cannot be caught under async reset, so it loads here
        if (boot_state == ccr_boot_load) begin
            next_lock = strap_sync;
            next_en0  = strap_sync;
        end
        if (wr_ctrl) begin
            next_en1   = write_data[`CCR_CTRL_EN1];
            next_spare = write_data[`CCR_CTRL_SPARE];
            // Bits 2:0 only move while unlocked
            if (!lock) begin
                next_en0 = write_data[`CCR_CTRL_EN0];
                // The lock accepts a single write, then holds
                if (!lock_written) begin
                    next_lock         = write_data[`CCR_CTRL_LOCK];
                    next_lock_written = 1'b1;
                end
            end
        end
        if (wr_sleep) begin
            next_slp1 = write_data[`CCR_SLP_EN1];
            // Comparator 0 sleep enable freezes under the lock
            if (!lock) begin
                next_slp0 = write_data[`CCR_SLP_EN0];
            end
        end
    end

    // Register storage; async reset gives constants only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lock                     <= `CCR_RST_BIT;
            lock_written             <= `CCR_RST_BIT;
            spare                    <= `CCR_RST_BIT;
            comparator0_enable       <= `CCR_RST_BIT;
            comparator1_enable       <= `CCR_RST_BIT;
            comparator0_sleep_enable <= `CCR_RST_BIT;
            comparator1_sleep_enable <= `CCR_RST_BIT;
        end else if (clock_enable) begin
            lock                     <= next_lock;
            lock_written             <= next_lock_written;
            spare                    <= next_spare;
            comparator0_enable       <= next_en0;
            comparator1_enable       <= next_en1;
            comparator0_sleep_enable <= next_slp0;
            comparator1_sleep_enable <= next_slp1;
        end
    end

    // Read mux; unmapped offsets and idle cycles give zero
    always_comb begin
        next_read_data = `CCR_RST_DATA;
        if (rd_any) begin
            if (address == `CCR_OFF_CTRL) begin
                next_read_data = compose_ctrl(comparator1_enable, spare, lock,
                                              comparator0_enable);
            end else if (address == `CCR_OFF_SLEEP) begin
                next_read_data = compose_sleep(comparator1_sleep_enable,
                                               comparator0_sleep_enable);
            end else begin
                next_read_data = `CCR_RST_DATA;
            end
        end
    end

    // Read data stands for the one cycle after the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= `CCR_RST_DATA;
        end else if (clock_enable) begin
            read_data <= next_read_data;
        end
    end

    // Checks on the register behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // A control write in the run phase
    sequence seq_ctrl_write;
        wr_ctrl;
    endsequence

    // A control write while comparator 0 is locked
    sequence seq_locked_write;
        wr_ctrl && lock;
    endsequence

    // A read of the control register
    sequence seq_ctrl_read;
        rd_any && (address == `CCR_OFF_CTRL);
    endsequence

    // A read of the sleep control register
    sequence seq_sleep_read;
        rd_any && (address == `CCR_OFF_SLEEP);
    endsequence

    a_cmp1_enable_write: assert property (
        seq_ctrl_write |=> comparator1_enable == $past(write_data[`CCR_CTRL_EN1]))
        else $error("comparator 1 enable did not follow write");

    a_cmp0_unlocked_write: assert property (
        seq_ctrl_write and !lock |=> comparator0_enable == $past(write_data[`CCR_CTRL_EN0]))
        else $error("comparator 0 enable ignored unlocked write");

    a_cmp0_locked_hold: assert property (
        seq_locked_write |=> lock && comparator0_enable == $past(comparator0_enable))
        else $error("locked bits changed on write");

    a_lock_write_once: assert property (
        seq_ctrl_write and lock_written |=> lock == $past(lock))
        else $error("lock changed after its one write");

    a_strap_defaults: assert property (
        clock_enable && boot_state == ccr_boot_load |=>
            lock == $past(strap_sync) && comparator0_enable == $past(strap_sync))
        else $error("strap defaults not loaded");

    a_sleep1_write: assert property (
        wr_sleep |=> comparator1_sleep_enable == $past(write_data[`CCR_SLP_EN1]))
        else $error("comparator 1 sleep enable did not follow write");

    a_sleep0_locked: assert property (
        wr_sleep && lock |=> comparator0_sleep_enable == $past(comparator0_sleep_enable))
        else $error("comparator 0 sleep enable changed while locked");

    // Field by field, so the check does not lean on the packing function
    a_ctrl_readback: assert property (
        seq_ctrl_read |=> read_data[`CCR_CTRL_EN1] == $past(comparator1_enable) &&
            read_data[`CCR_CTRL_SPARE] == $past(spare) &&
            read_data[`CCR_CTRL_LOCK] == $past(lock) &&
            read_data[`CCR_CTRL_EN0+1] == 1'b0 &&
            read_data[`CCR_CTRL_EN0] == $past(comparator0_enable))
        else $error("control readback mismatch");

    // Sleep image carries both enables over zero upper bits
    a_sleep_readback: assert property (
        seq_sleep_read |=> read_data[`CCR_SLP_EN1] == $past(comparator1_sleep_enable) &&
            read_data[`CCR_SLP_EN0] == $past(comparator0_sleep_enable) &&
            read_data[`CCR_DATA_W-1:`CCR_SLP_EN1+1] == 6'h00)
        else $error("sleep readback mismatch");

    // Read data falls back to zero after an idle cycle
    a_read_idle_zero: assert property (
        clock_enable && !read_strobe |=> read_data == `CCR_RST_DATA)
        else $error("read data did not return to zero");

    // The single lock write takes the written value
    a_lock_first_write: assert property (
        seq_ctrl_write and (!lock && !lock_written) |=>
            lock == $past(write_data[`CCR_CTRL_LOCK]) && lock_written)
        else $error("first lock write not taken");

    // Unlocked sleep writes reach comparator 0 sleep enable
    a_sleep0_unlocked: assert property (
        wr_sleep && !lock |=> comparator0_sleep_enable == $past(write_data[`CCR_SLP_EN0]))
        else $error("comparator 0 sleep enable ignored unlocked write");

    // Control bit 3 always stores what was written
    a_spare_store: assert property (
        seq_ctrl_write |=> spare == $past(write_data[`CCR_CTRL_SPARE]))
        else $error("control bit 3 did not store write");

    // Comparator 1 enable moves only on a control write
    a_cmp1_hold: assert property (
        !wr_ctrl |=> $stable(comparator1_enable))
        else $error("comparator 1 enable changed without a write");

    a_reserved_zero: assert property (
        read_data[`CCR_DATA_W-1:`CCR_CTRL_EN1+1] == 3'h0)
        else $error("reserved read bits not zero");

    a_boot_no_write: assert property (
        boot_state != ccr_boot_run && !(clock_enable && boot_state == ccr_boot_load)
            |=> comparator1_enable == $past(comparator1_enable))
        else $error("register changed during boot");

endmodule
`default_nettype wire

// ---- ccr_params.svh ----
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// Register offsets on the local register port
`define CCR_ADDR_W         8
`define CCR_DATA_W         8
`define CCR_OFF_CTRL       8'h94
`define CCR_OFF_SLEEP      8'h98

// Control register field positions
`define CCR_CTRL_EN0       0
`define CCR_CTRL_LOCK      2
`define CCR_CTRL_SPARE     3
`define CCR_CTRL_EN1       4

// Sleep control register field positions
`define CCR_SLP_EN0        0
`define CCR_SLP_EN1        1

// Reset values
`define CCR_RST_BIT        1'b0
`define CCR_RST_DATA       8'h00

`endif

// ---- ccr_pkg.sv ----
package ccr_pkg;

    // Boot sequence that waits for the synchronised strap, then loads it
    typedef enum logic [1:0] {
        ccr_boot_fill0 = 2'b00,
        ccr_boot_fill1 = 2'b01,
        ccr_boot_load  = 2'b10,
        ccr_boot_run   = 2'b11
    } ccr_boot_t;

endpackage

// ---- tb_ccr_comparator_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ccr_params.svh"

module tb_ccr_comparator_regs;
    logic       clock;          // 50 MHz bench clock
    logic       reset_n;        // Active-low reset
    logic       clock_enable;   // Global advance enable
    logic [7:0] address;        // Register offset
    logic [7:0] write_data;     // Write word
    logic       write_strobe;   // One-cycle write
    logic       read_strobe;    // One-cycle read
    logic [7:0] read_data;      // Registered read word
    logic       strap;          // Boot strap level
    logic       c0e;            // Comparator 0 enable
    logic       c1e;            // Comparator 1 enable
    logic       c0s;            // Comparator 0 sleep enable
    logic       c1s;            // Comparator 1 sleep enable
    int         bad_count;      // Mismatches
    int         check_count;    // Comparisons

    ccr_comparator_regs ccr_comparator_regs_inst (
        .clock                     (clock),
        .reset_n                   (reset_n),
        .clock_enable              (clock_enable),
        .address                   (address),
        .write_data                (write_data),
        .write_strobe              (write_strobe),
        .read_strobe               (read_strobe),
        .read_data                 (read_data),
        .comparator_boot_strap_pin (strap),
        .comparator0_enable        (c0e),
        .comparator1_enable        (c1e),
        .comparator0_sleep_enable  (c0s),
        .comparator1_sleep_enable  (c1s)
    );

    // Free-running clock
    always #10 clock = ~clock;

    // Compare and count; unknowns never match
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Output pins packed as {c1s, c0s, c1e, c0e}
    task automatic chk_pins(input logic [3:0] exp);
        chk("pins", {4'h0, exp}, {4'h0, c1s, c0s, c1e, c0e});
    endtask

    // One-cycle write, strobe dropped at the next edge
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address      <= a;
        write_data   <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    // Read, check the data cycle, then check that it falls back to zero
    task automatic bus_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        address     <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        chk("read_data", exp, read_data);
        @(posedge clock);
        #1;
        chk("read_data idle", 8'h00, read_data);
    endtask

    // Reset with a given strap level, then let the boot phase finish
    task automatic do_reset(input logic s);
        @(posedge clock);
        strap   <= s;
        reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
    endtask

    // Strap low: everything comes up zero
    task automatic run_defaults;
        do_reset(1'b0);
        chk_pins(4'h0);
        bus_read(`CCR_OFF_CTRL, 8'h00);
        bus_read(`CCR_OFF_SLEEP, 8'h00);
    endtask

    // Sleep bits take writes while unlocked; upper bits read zero
    task automatic run_sleep_bits;
        bus_write(`CCR_OFF_SLEEP, 8'hff);
        bus_read(`CCR_OFF_SLEEP, 8'h03);
        chk_pins(4'hc);
    endtask

    // First control write lands fully, bit 1 and 7:5 stay zero
    task automatic run_ctrl_lock;
        bus_write(`CCR_OFF_CTRL, 8'hff);
        bus_read(`CCR_OFF_CTRL, 8'h1d);
        chk_pins(4'hf);
    endtask

    // With lock set, bits 2:0 and sleep bit 0 hold; bits 4 and 3 move
    task automatic run_frozen;
        bus_write(`CCR_OFF_CTRL, 8'h00);
        bus_read(`CCR_OFF_CTRL, 8'h05);
        bus_write(`CCR_OFF_SLEEP, 8'h00);
        bus_read(`CCR_OFF_SLEEP, 8'h01);
        chk_pins(4'h5);
        bus_read(8'h90, 8'h00);
    endtask

    // Mid-run reset with strap high presets lock and enable 0
    task automatic run_strap_boot;
        do_reset(1'b1);
        bus_read(`CCR_OFF_CTRL, 8'h05);
        bus_read(`CCR_OFF_SLEEP, 8'h00);
        chk_pins(4'h1);
        bus_write(`CCR_OFF_CTRL, 8'h00);
        bus_read(`CCR_OFF_CTRL, 8'h05);
        bus_write(`CCR_OFF_SLEEP, 8'h02);
        // Frozen clock enable must swallow a write
        @(posedge clock);
        clock_enable <= 1'b0;
        bus_write(`CCR_OFF_CTRL, 8'h18);
        clock_enable <= 1'b1;
        bus_read(`CCR_OFF_CTRL, 8'h05);
        bus_write(`CCR_OFF_CTRL, 8'h18);
        bus_read(`CCR_OFF_CTRL, 8'h1d);
        chk_pins(4'hb);
    endtask

    // Unlocked bits 2:0 follow writes; a lock written 0 stays 0
    task automatic run_lock_once;
        do_reset(1'b0);
        bus_write(`CCR_OFF_SLEEP, 8'h01);
        bus_write(`CCR_OFF_CTRL, 8'h01);
        bus_read(`CCR_OFF_CTRL, 8'h01);
        bus_write(`CCR_OFF_CTRL, 8'h00);
        bus_read(`CCR_OFF_CTRL, 8'h00);
        bus_write(`CCR_OFF_CTRL, 8'h04);
        bus_read(`CCR_OFF_CTRL, 8'h00);
        bus_write(`CCR_OFF_SLEEP, 8'h00);
        bus_read(`CCR_OFF_SLEEP, 8'h00);
        chk_pins(4'h0);
    endtask

    // Single place that prints the verdict
    task automatic end_sim;
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        clock        = 1'b0;
        reset_n      = 1'b0;
        clock_enable = 1'b1;
        address      = 8'h00;
        write_data   = 8'h00;
        write_strobe = 1'b0;
        read_strobe  = 1'b0;
        strap        = 1'b0;
        bad_count    = 0;
        check_count  = 0;
        run_defaults();
        run_sleep_bits();
        run_ctrl_lock();
        run_frozen();
        run_strap_boot();
        run_lock_once();
        end_sim();
    end
endmodule
`default_nettype wire
